// [tracker_regs_pkg.sv]
// constants for the tracker configuration and status register bank
`default_nettype none
package tracker_regs_pkg;
  // ---------------------------------------------------------------
  // register geometry
  // ---------------------------------------------------------------
  localparam int REG_WIDTH   = 56;              // bits per register
  localparam int REG_BYTES   = 7;               // bytes per transfer
  localparam int SAMPLE_W    = 10;              // conversion width
  localparam logic [7:0] CMD_BASE = 8'he0;      // command code base
  // register select codes, offset from the base
  localparam logic [7:0] CMD_CONFIG_READBACK = 8'he0;
  localparam logic [7:0] CMD_MEASUREMENT     = 8'he1;
  localparam logic [7:0] CMD_CONVERTER_CTRL  = 8'he3;
  // ---------------------------------------------------------------
  // field positions (low bit of each field; CTRL_USED_MSB is the top used control bit)
  // ---------------------------------------------------------------
  localparam int CH0_LSB       = 0;
  localparam int CH2_LSB       = 10;
  localparam int CH4_LSB       = 20;
  localparam int CH6_LSB       = 30;
  localparam int IIN_LSB       = 0;
  localparam int VIN_LSB       = 10;
  localparam int IOUT_LSB      = 20;
  localparam int VOUT_LSB      = 30;
  localparam int TRACK_OK_BIT  = 40;
  localparam int OVERVOLT_BIT  = 41;
  localparam int OVERTEMP_BIT  = 42;
  localparam int OPEN_LOOP_BIT = 0;
  localparam int CLK_OE_BIT    = 1;
  localparam int SOFT_RST_BIT  = 2;
  localparam int BYP_MAN_BIT   = 3;
  localparam int BYP_SEL_BIT   = 4;
  localparam int DUTY_LSB      = 5;
  localparam int TDON_LSB      = 14;
  localparam int TDOFF_LSB     = 17;
  localparam int VMAX_LSB      = 20;
  localparam int IMAX_LSB      = 30;
  localparam int BYP_SET_LSB   = 40;
  localparam int PWR_THR_BIT   = 42;
  localparam int OVERRIDE_BIT  = 46;
  localparam int CTRL_USED_MSB = 46;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [9:0] MAX_RESET      = 10'h3ff;
  localparam logic [2:0] DEADTIME_RESET = 3'h3;
  localparam logic [8:0] DUTY_RESET     = 9'h0ff;
  localparam logic [REG_WIDTH-1:0] CTRL_RESET =
    {9'h000, 1'b0, 1'b0, 2'h0, 1'b0, 2'h0, MAX_RESET, MAX_RESET,
     DEADTIME_RESET, DEADTIME_RESET, DUTY_RESET, 5'h00};
endpackage : tracker_regs_pkg
`default_nettype wire

// [tracker_config_status_regs.sv]
// register bank of the tracking converter controller
`timescale 1ns/1ps
`default_nettype none
module tracker_config_status_regs
  import tracker_regs_pkg::*;
(
  input  wire logic                     clock,          // 20 MHz
  input  wire logic                     resetn,         // async, low
  // register port from the serial-bus command decoder
  input  wire logic [7:0]               reg_command,    // select code
  input  wire logic                     reg_write,      // write strobe
  input  wire logic [REG_WIDTH-1:0]     reg_wdata,      // all 56 bits
  output logic [REG_WIDTH-1:0]          reg_rdata,      // registered
  output logic                          reg_cmd_valid,  // code known
  // analog conversion results
  input  wire logic [SAMPLE_W-1:0]      config_ch0,
  input  wire logic [SAMPLE_W-1:0]      config_ch2,
  input  wire logic [SAMPLE_W-1:0]      config_ch4,
  input  wire logic [SAMPLE_W-1:0]      config_ch6,
  input  wire logic [SAMPLE_W-1:0]      sample_vout,
  input  wire logic [SAMPLE_W-1:0]      sample_iout,
  input  wire logic [SAMPLE_W-1:0]      sample_vin,
  input  wire logic [SAMPLE_W-1:0]      sample_iin,
  // pins and internal status
  input  wire logic                     overtemp_n_pin,   // pin
  input  wire logic                     overvoltage_flag, // pin
  input  wire logic                     bypass_request_pin, // low=on
  input  wire logic                     tracking_start_ok,
  input  wire logic                     pll_clock,      // free clock
  // control outputs to the converter logic
  output logic                          cfg_power_thr_sel,
  output logic [1:0]                    cfg_bypass_setting,
  output logic [SAMPLE_W-1:0]           cfg_iout_max,
  output logic [SAMPLE_W-1:0]           cfg_vout_max,
  output logic [SAMPLE_W-1:0]           cfg_slew_code,
  output logic [2:0]                    deadtime_off,
  output logic [2:0]                    deadtime_on,
  output logic [8:0]                    commanded_duty_open,
  output logic                          tracking_disable,
  output logic                          bypass_mode_request,
  output logic                          converter_soft_reset,
  output logic                          clock_out_pin
);
  // ---------------------------------------------------------------
  // geometry guard
  // ---------------------------------------------------------------
  // the slices below assume ten-bit samples packed in seven bytes
  if (REG_WIDTH != REG_BYTES * 8 || SAMPLE_W != 10) begin : g_geometry
    $error("register geometry does not fit the field layout");
  end

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rst_meta_q;  // first stage, read only by second
  logic rst_n_q;     // synchronous release copy

  // async assert, release after two edges
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] pin_meta_q;  // first stages
  logic [2:0] pin_sync_q;  // usable copies

  // overtemp, overvoltage, bypass pin; two flops each
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      // bypass stages rest at the pin's idle high level, so no false
      // bypass request follows the release of reset
      pin_meta_q <= 3'h4;
      pin_sync_q <= 3'h4;
    end else begin
      pin_meta_q <= {bypass_request_pin, overvoltage_flag,
                     overtemp_n_pin};
      pin_sync_q <= pin_meta_q;
    end
  end

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  logic [REG_WIDTH-1:0] ctrl_q;  // converter_control image

  // whole-word write only; partial writes cannot exist here
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctrl_q <= CTRL_RESET;
    end else if (reg_write && reg_command == CMD_CONVERTER_CTRL) begin
      ctrl_q <= reg_wdata;
    end
  end

  // ---------------------------------------------------------------
  // status images
  // ---------------------------------------------------------------
  logic [REG_WIDTH-1:0] readback_q;  // config_channel_readback
  logic [REG_WIDTH-1:0] measure_q;   // measurement_status

  // sampled every cycle so a read returns a coherent word
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      readback_q <= '0;
      measure_q  <= '0;
    end else begin
      readback_q <= {16'h0000, config_ch6, config_ch4,
                     config_ch2, config_ch0};
      measure_q  <= {13'h0000,
                     pin_sync_q[0],
                     pin_sync_q[1],
                     tracking_start_ok,
                     sample_vout, sample_iout,
                     sample_vin, sample_iin};
    end
  end

  // ---------------------------------------------------------------
  // register read port
  // ---------------------------------------------------------------
  // unknown codes read zero and flag invalid
  always_comb begin
    reg_cmd_valid = 1'b1;
    case (reg_command)
      CMD_CONFIG_READBACK: reg_cmd_valid = 1'b1;
      CMD_MEASUREMENT:     reg_cmd_valid = 1'b1;
      CMD_CONVERTER_CTRL:  reg_cmd_valid = 1'b1;
      default:             reg_cmd_valid = 1'b0;
    endcase
  end

  // read data held in flops, all 56 bits at once
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      reg_rdata <= '0;
    end else begin
      case (reg_command)
        CMD_CONFIG_READBACK: reg_rdata <= readback_q;
        CMD_MEASUREMENT:     reg_rdata <= measure_q;
        CMD_CONVERTER_CTRL:  reg_rdata <= ctrl_q;
        default:             reg_rdata <= '0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // configuration selection and converter controls
  // ---------------------------------------------------------------
  logic ovr;  // override select
  // one bit swaps every overridable field at once
  assign ovr = ctrl_q[OVERRIDE_BIT];

  // registered so downstream never sees a half-switched config
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cfg_power_thr_sel    <= 1'b0;
      cfg_bypass_setting   <= 2'h0;
      cfg_iout_max         <= '0;
      cfg_vout_max         <= '0;
      cfg_slew_code        <= '0;
      deadtime_off         <= DEADTIME_RESET;
      deadtime_on          <= DEADTIME_RESET;
      commanded_duty_open  <= DUTY_RESET;
      tracking_disable     <= 1'b0;
      bypass_mode_request  <= 1'b0;
      converter_soft_reset <= 1'b0;
    end else begin
      cfg_power_thr_sel  <= ovr ? ctrl_q[PWR_THR_BIT]
                                : readback_q[CH2_LSB+9];
      cfg_bypass_setting <= ovr ? ctrl_q[BYP_SET_LSB +: 2]
                                : readback_q[CH2_LSB+7 +: 2];
      cfg_iout_max <= ovr ? ctrl_q[IMAX_LSB +: SAMPLE_W]
                          : readback_q[CH4_LSB +: SAMPLE_W];
      cfg_vout_max <= ovr ? ctrl_q[VMAX_LSB +: SAMPLE_W]
                          : readback_q[CH0_LSB +: SAMPLE_W];
      // channel 6 has no override field, so it always comes from the config_ch6 readback image
      cfg_slew_code <= readback_q[CH6_LSB +: SAMPLE_W];
      deadtime_off  <= ctrl_q[TDOFF_LSB +: 3];
      deadtime_on   <= ctrl_q[TDON_LSB +: 3];
      commanded_duty_open <= ctrl_q[DUTY_LSB +: 9];
      tracking_disable    <= ctrl_q[OPEN_LOOP_BIT];
      // pin is active low; register bit is active high
      bypass_mode_request <= ctrl_q[BYP_SEL_BIT]
                             ? ctrl_q[BYP_MAN_BIT]
                             : ~pin_sync_q[2];
      converter_soft_reset <= ctrl_q[SOFT_RST_BIT];
    end
  end

  // gated clock out; glitches possible when toggled mid-cycle
  assign clock_out_pin = pll_clock & ctrl_q[CLK_OE_BIT];

endmodule : tracker_config_status_regs
`default_nettype wire

// [tracker_regs_monitor.sv]
// port checker for the tracker register bank
`timescale 1ns/1ps
`default_nettype none
module tracker_regs_monitor
  import tracker_regs_pkg::*;
(
  input wire logic                 clock,
  input wire logic                 resetn,
  input wire logic [7:0]           reg_command,
  input wire logic                 reg_write,
  input wire logic [REG_WIDTH-1:0] reg_wdata,
  input wire logic [REG_WIDTH-1:0] reg_rdata,
  input wire logic                 reg_cmd_valid,
  input wire logic                 pll_clock,
  input wire logic                 clock_out_pin,
  input wire logic [SAMPLE_W-1:0]  cfg_vout_max,
  input wire logic [2:0]           deadtime_off,
  input wire logic [2:0]           deadtime_on,
  input wire logic [8:0]           commanded_duty_open,
  input wire logic                 tracking_disable,
  input wire logic                 bypass_mode_request,
  input wire logic                 converter_soft_reset
);
  // ----------------------------------------------------------
  // checks, one domain
  // ----------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // control write taken at this edge
  wire logic wr = reg_write && (reg_command == CMD_CONVERTER_CTRL);
  logic oe_q;  // last clock-out enable written
  // shadow of control bit 1, cleared with the bank
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      oe_q <= 1'b0;
    end else if (wr) begin
      oe_q <= reg_wdata[1];
    end
  end
  property p_cmd;
    reg_cmd_valid == (reg_command inside {8'he0, 8'he1, 8'he3});
  endproperty
  a_cmd: assert property (p_cmd) else $error("select flag wrong");
  property p_unk; !reg_cmd_valid |=> reg_rdata == '0; endproperty
  a_unk: assert property (p_unk) else $error("unknown not zero");
  property p_dead;
    wr |=> ##1 {deadtime_off, deadtime_on} == $past(reg_wdata[19:14], 2);
  endproperty
  a_dead: assert property (p_dead) else $error("dead time");
  property p_duty;
    wr |=> ##1 commanded_duty_open == $past(reg_wdata[13:5], 2);
  endproperty
  a_duty: assert property (p_duty) else $error("duty field");
  property p_open;
    wr |=> ##1 {tracking_disable, converter_soft_reset} ==
      {$past(reg_wdata[0], 2), $past(reg_wdata[2], 2)};
  endproperty
  a_open: assert property (p_open) else $error("open loop");
  property p_byp;
    wr && reg_wdata[4] |=> ##1 bypass_mode_request == $past(reg_wdata[3], 2);
  endproperty
  a_byp: assert property (p_byp) else $error("bypass");
  property p_ovr;
    wr && reg_wdata[46] |=> ##1 cfg_vout_max == $past(reg_wdata[29:20], 2);
  endproperty
  a_ovr: assert property (p_ovr) else $error("override");
  property p_clk; clock_out_pin == (pll_clock && oe_q); endproperty
  a_clk: assert property (p_clk) else $error("clock out");
endmodule : tracker_regs_monitor
`default_nettype wire

// [tracker_host_model.sv]
// host model issuing whole-word register requests
`timescale 1ns/1ps
`default_nettype none
module tracker_host_model
  import tracker_regs_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic [REG_WIDTH-1:0] reg_rdata,
  output var logic [7:0]            reg_command,
  output var logic                  reg_write,
  output var logic [REG_WIDTH-1:0]  reg_wdata
);
  initial begin
    reg_command = CMD_CONFIG_READBACK;
    reg_write = 1'b0;
    reg_wdata = '0;
  end
  // one strobe carries all 56 bits; no partial words
  task automatic wr(input logic [7:0] c, input logic [REG_WIDTH-1:0] w);
    @(posedge clock);
    reg_command <= c;
    reg_write <= 1'b1;
    reg_wdata <= w;
    @(posedge clock);
    reg_write <= 1'b0;
    reg_wdata <= ~w; // stale word is not left behind
  endtask : wr
  // select, then take the word after the sampling edge
  task automatic rd(input logic [7:0] c, output logic [REG_WIDTH-1:0] d);
    @(posedge clock);
    reg_command <= c;
    @(posedge clock);
    #1 d = reg_rdata;
  endtask : rd
endmodule : tracker_host_model
`default_nettype wire

// [test_tracker_config_status_regs.sv]
// self-checking bench for the tracker register bank
`timescale 1ns/1ps
`default_nettype none
module test_tracker_config_status_regs;
  import tracker_regs_pkg::*;
  logic clock, resetn, reg_write, pll_clock, overtemp_n_pin;
  logic overvoltage_flag, bypass_request_pin, tracking_start_ok;
  logic [7:0] reg_command;
  logic [REG_WIDTH-1:0] reg_wdata, reg_rdata, word, got;
  logic [SAMPLE_W-1:0] config_ch0, config_ch2, config_ch4, config_ch6;
  logic [SAMPLE_W-1:0] sample_vout, sample_iout, sample_vin, sample_iin;
  logic [SAMPLE_W-1:0] cfg_iout_max, cfg_vout_max, cfg_slew_code;
  logic [2:0] deadtime_off, deadtime_on;
  logic [8:0] commanded_duty_open;
  logic [1:0] cfg_bypass_setting;
  logic reg_cmd_valid, cfg_power_thr_sel, tracking_disable;
  logic bypass_mode_request, converter_soft_reset, clock_out_pin;
  logic [4:0] seq [3] = '{5'h01, 5'h05, 5'h03};
  int fails, comparisons;
  tracker_config_status_regs u_dut (
    .clock(clock), .resetn(resetn), .reg_command(reg_command),
    .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_cmd_valid(reg_cmd_valid), .config_ch0(config_ch0),
    .config_ch2(config_ch2), .config_ch4(config_ch4),
    .config_ch6(config_ch6), .sample_vout(sample_vout),
    .sample_iout(sample_iout), .sample_vin(sample_vin),
    .sample_iin(sample_iin), .overtemp_n_pin(overtemp_n_pin),
    .overvoltage_flag(overvoltage_flag),
    .bypass_request_pin(bypass_request_pin),
    .tracking_start_ok(tracking_start_ok), .pll_clock(pll_clock),
    .cfg_power_thr_sel(cfg_power_thr_sel),
    .cfg_bypass_setting(cfg_bypass_setting),
    .cfg_iout_max(cfg_iout_max), .cfg_vout_max(cfg_vout_max),
    .cfg_slew_code(cfg_slew_code), .deadtime_off(deadtime_off),
    .deadtime_on(deadtime_on), .commanded_duty_open(commanded_duty_open),
    .tracking_disable(tracking_disable),
    .bypass_mode_request(bypass_mode_request),
    .converter_soft_reset(converter_soft_reset),
    .clock_out_pin(clock_out_pin));
  tracker_host_model u_host (
    .clock(clock), .reg_rdata(reg_rdata), .reg_command(reg_command),
    .reg_write(reg_write), .reg_wdata(reg_wdata));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic check(input logic [REG_WIDTH-1:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // pins pass two sync stages, then the image, then the read port
  task automatic settle();
    repeat (5) @(posedge clock);
    #1;
  endtask : settle
  task automatic summarize();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize
  initial begin
    #1ms;
    fails++;
    summarize();
  end
  initial begin
    {resetn, pll_clock, tracking_start_ok, overvoltage_flag} = 4'h0;
    {overtemp_n_pin, bypass_request_pin} = 2'h3;
    {config_ch6, config_ch4, config_ch2, config_ch0} =
      {10'h2aa, 10'h155, 10'h0c0, 10'h0a5};
    {sample_vout, sample_iout, sample_vin, sample_iin} =
      {10'h201, 10'h102, 10'h3fe, 10'h07f};
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    // writes to read-only and unknown codes are dropped
    u_host.wr(CMD_CONFIG_READBACK, '0);
    u_host.wr(8'he2, '0);
    u_host.rd(CMD_CONVERTER_CTRL, got);
    check(got, 56'h0000fffff6dfe0);
    check({deadtime_off, deadtime_on, commanded_duty_open}, 15'h36ff);
    u_host.rd(8'he2, got);
    check(reg_cmd_valid, 1'b0);
    check(got, '0);
    u_host.rd(CMD_CONFIG_READBACK, got);
    check(got, {16'h0, config_ch6, config_ch4, config_ch2, config_ch0});
    for (int i = 0; i < 2; i++) begin
      @(posedge clock);
      {overtemp_n_pin, overvoltage_flag, tracking_start_ok} <= i ? 3'h2 : 3'h5;
      settle();
      u_host.rd(CMD_MEASUREMENT, got);
      check(got, {13'h0, overtemp_n_pin, overvoltage_flag, tracking_start_ok,
        sample_vout, sample_iout, sample_vin, sample_iin});
    end
    $display("test access done");
    for (int i = 0; i < 2; i++) begin
      word = {9'h0, ~i[0], 3'h0, 1'b1, 2'h2, 10'h123, 10'h2c4,
              3'h5, 3'h6, 9'h1a5, 5'h00};
      u_host.wr(CMD_CONVERTER_CTRL, word);
      settle();
      check(cfg_vout_max, i ? config_ch0 : 10'h2c4);
      check(cfg_iout_max, i ? config_ch4 : 10'h123);
      check(cfg_power_thr_sel, i ? config_ch2[9] : 1'b1);
      check(cfg_bypass_setting, i ? config_ch2[8:7] : 2'h2);
      check(cfg_slew_code, config_ch6);
      check({deadtime_off, deadtime_on, commanded_duty_open}, 15'h5da5);
      u_host.rd(CMD_CONVERTER_CTRL, got);
      check(got, word);
    end
    $display("test override done");
    for (int i = 0; i < 8; i++) begin
      @(posedge clock);
      bypass_request_pin <= i[2];
      pll_clock <= 1'b1;
      u_host.wr(CMD_CONVERTER_CTRL, {51'h0, i[1:0], 3'h0});
      settle();
      check(bypass_mode_request, i[1] ? i[0] : !i[2]);
    end
    $display("test bypass done");
    for (int i = 0; i < 3; i++) begin
      u_host.wr(CMD_CONVERTER_CTRL, {51'h0, seq[i]});
      settle();
      check({tracking_disable, converter_soft_reset, clock_out_pin},
        {seq[i][0], seq[i][2], seq[i][1]});
    end
    @(posedge clock);
    pll_clock <= 1'b0;
    @(posedge clock);
    #1 check(clock_out_pin, 1'b0);
    $display("test open loop done");
    // mid-run reset brings every control back to its reset image
    @(posedge clock);
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    #1 check({deadtime_off, deadtime_on, commanded_duty_open}, 15'h36ff);
    check({tracking_disable, converter_soft_reset}, 2'h0);
    @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    u_host.rd(CMD_CONVERTER_CTRL, got);
    check(got, 56'h0000fffff6dfe0);
    $display("test reset done");
    summarize();
  end
endmodule : test_tracker_config_status_regs
bind tracker_config_status_regs tracker_regs_monitor u_mon (
  .clock(clock), .resetn(resetn), .reg_command(reg_command),
  .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_cmd_valid(reg_cmd_valid), .pll_clock(pll_clock),
  .clock_out_pin(clock_out_pin), .cfg_vout_max(cfg_vout_max),
  .deadtime_off(deadtime_off), .deadtime_on(deadtime_on),
  .commanded_duty_open(commanded_duty_open),
  .tracking_disable(tracking_disable),
  .bypass_mode_request(bypass_mode_request),
  .converter_soft_reset(converter_soft_reset));
`default_nettype wire
